/* shared/ulm_defines.svh */
/*
 * Register offsets, field positions, reset values and bit-timing counts
 * for the line, modem-output and status logic of the serial port.
 * Assumes an 8-bit register port with a 3-bit address.
 */
`ifndef ULM_DEFINES_SVH
`define ULM_DEFINES_SVH
// register offsets
`define ULM_OFF_DATA 3'h0
`define ULM_OFF_IEN 3'h1
`define ULM_OFF_FEAT 3'h2
`define ULM_OFF_LFC 3'h3
`define ULM_OFF_MOC 3'h4
`define ULM_OFF_LTS 3'h5
// reset values and the enhanced-register key
`define ULM_LFC_RST 8'h00
`define ULM_MOC_RST 8'h00
`define ULM_DIV_RST 16'h0001
`define ULM_ENH_KEY 8'hBF
// line_format_control fields
`define ULM_LFC_STB 2
`define ULM_LFC_PEN 3
`define ULM_LFC_EPS 4
`define ULM_LFC_SP 5
`define ULM_LFC_BRK 6
`define ULM_LFC_DLAB 7
// modem_output_control fields
`define ULM_MOC_DTR 0
`define ULM_MOC_RTS 1
`define ULM_MOC_OP1 2
`define ULM_MOC_OP2 3
`define ULM_MOC_LOOP 4
`define ULM_MOC_OSRC 5
`define ULM_MOC_IR 6
`define ULM_MOC_PRE 7
// interrupt_enable_control, enhanced and extra feature fields
`define ULM_IEN_RDA 0
`define ULM_IEN_THRE 1
`define ULM_IEN_LS 2
`define ULM_EFR_ARTS 6
`define ULM_XFR_BAD 3
// bit timing in oversample ticks; the prescaler count is in clocks
`define ULM_OVS 6'h10
`define ULM_STOP15 6'h18
`define ULM_STOP2 6'h20
`define ULM_IR_PW 6'h03
`define ULM_IR_HOLD 5'h10
`define ULM_RX_MID 4'h7
`define ULM_RX_LAST 4'hF
`define ULM_PRE_LAST 2'h3
`endif

/* shared/ulm_pkg.sv */
/*
 * Types for the serial line block: state enums and the received
 * character carrier. Assumes nothing of its surroundings.
 */
package ulm_pkg;
    // transmitter sequence
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulm_tx_state_t;
    // receiver sequence
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRKW} ulm_rx_state_t;
    // one received character with its own error flags
    typedef struct packed {
        logic [7:0] data;
        logic par_err;
        logic frm_err;
        logic brk;
    } ulm_rx_char_t;
endpackage : ulm_pkg

/* rtl/ulm_line_ctrl.sv */
/*
 * Serial transceiver core: character format, break, divisor select,
 * modem-control outputs, loopback, infrared routing, prescaler and
 * line status, with single holding registers on both directions.
 * Assumes one 50 MHz clock, synchronous inputs and a register master
 * that never needs a wait state.
 */
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "ulm_defines.svh"

module ulm_line_ctrl (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // synchronous reset
    input wire logic [2:0] reg_addr, // register offset
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic serial_in, // serial or infrared receive
    output logic serial_out, // serial or infrared transmit
    input wire logic infrared_select_pin, // infrared strap
    input wire logic pc_bus_mode, // high selects pc bus mode
    output logic dtr_n, // terminal ready
    output logic rts_n, // request to send
    output logic gp_output_one_n, // general output one
    output logic gp_output_two_n, // general output two
    output logic pc_interrupt_request, // gated interrupt, pc mode
    output logic int_out, // interrupt level
    output logic int_oe_n // interrupt pin enable, low drives
);

    ////////////////////////////////////////////////////////////////////
    logic [7:0] lfc_q;
    logic [7:0] moc_q;
    logic [2:0] ien_q;
    logic efr_arts_q;
    logic xfr_bad_q;
    logic [15:0] div_q;
    logic strap_q;
    logic [7:0] thr_q;
    logic thr_empty_q;
    logic [7:0] tsr_q;
    ulm_pkg::ulm_tx_state_t tx_st_q;
    logic [5:0] tx_tck_q;
    logic [2:0] tx_bit_q;
    logic [1:0] pre_q;
    logic [15:0] div_cnt_q;
    logic [4:0] ir_cnt_q;
    ulm_pkg::ulm_rx_state_t rx_st_q;
    logic [3:0] rx_tck_q;
    logic [2:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    logic rx_pe_q;
    logic rx_zero_q;
    ulm_pkg::ulm_rx_char_t hold_q;
    ulm_pkg::ulm_rx_char_t rx_new;
    logic dr_q;
    logic oe_q;
    logic ls_pend_q;
    logic [7:0] rdata_d;
    logic dlab, wr_thr, rd_rhr, rd_lts, pre_tick, tick;
    logic [15:0] div_m1;
    logic [5:0] stop_len, tx_len;
    logic tx_last, tx_bit, tx_line, ir_enc, rx_line, rx_done, rx_err;
    logic [2:0] wl_last;
    logic [7:0] lts;
    logic int_any;

    // parity bit for the active word length and parity mode
    function automatic logic par_calc(input logic [7:0] d, input logic [1:0] wl,
                                      input logic eps, input logic sp);
        logic [7:0] md;
        md = d & (8'hFF >> (2'h3 - wl));
        if (sp) begin
            par_calc = !eps;
        end else begin
            par_calc = eps ? ^md : ~^md;
        end
    endfunction : par_calc

    ////////////////////////////////////////////////////////////////////
    // divisor access select
    assign dlab = lfc_q[`ULM_LFC_DLAB] && (lfc_q != `ULM_ENH_KEY);
    assign wr_thr = reg_wr && (reg_addr == `ULM_OFF_DATA) && !dlab;
    assign rd_rhr = reg_rd && (reg_addr == `ULM_OFF_DATA) && !dlab;
    assign rd_lts = reg_rd && (reg_addr == `ULM_OFF_LTS);

    // software-written configuration; the strap loads once after reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lfc_q <= `ULM_LFC_RST;
            moc_q <= `ULM_MOC_RST;
            ien_q <= 3'h0;
            efr_arts_q <= 1'b0;
            xfr_bad_q <= 1'b0;
            div_q <= `ULM_DIV_RST;
            strap_q <= 1'b0;
        end else begin
            if (!strap_q) begin
                strap_q <= 1'b1;
                moc_q[`ULM_MOC_IR] <= infrared_select_pin;
            end
            if (reg_wr) begin
                case (reg_addr)
                    `ULM_OFF_DATA: if (dlab) div_q[7:0] <= reg_wdata;
                    `ULM_OFF_IEN: begin
                        if (dlab) begin
                            div_q[15:8] <= reg_wdata;
                        end else begin
                            ien_q <= reg_wdata[2:0];
                        end
                    end
                    `ULM_OFF_FEAT: begin
                        if (lfc_q == `ULM_ENH_KEY) begin
                            efr_arts_q <= reg_wdata[`ULM_EFR_ARTS];
                        end else begin
                            xfr_bad_q <= reg_wdata[`ULM_XFR_BAD];
                        end
                    end
                    `ULM_OFF_LFC: lfc_q <= reg_wdata;
                    `ULM_OFF_MOC: moc_q <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // divide by four
    assign pre_tick = !moc_q[`ULM_MOC_PRE] || (pre_q == `ULM_PRE_LAST);
    // a zero divisor runs as one rather than stalling the line
    assign div_m1 = (div_q == 16'h0000) ? 16'h0000 : div_q - 16'h0001;
    assign tick = pre_tick && (div_cnt_q >= div_m1);

    // prescaler and divisor counter giving the oversample tick
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pre_q <= 2'h0;
            div_cnt_q <= 16'h0000;
        end else begin
            pre_q <= pre_q + 2'h1;
            if (tick) begin
                div_cnt_q <= 16'h0000;
            end else if (pre_tick) begin
                div_cnt_q <= div_cnt_q + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // last data bit index
    assign wl_last = 3'h4 + {1'b0, lfc_q[1:0]};
    assign stop_len = !lfc_q[`ULM_LFC_STB] ? `ULM_OVS :
                      (lfc_q[1:0] == 2'h0) ? `ULM_STOP15 : `ULM_STOP2;
    assign tx_len = (tx_st_q == ulm_pkg::TX_STOP) ? stop_len : `ULM_OVS;
    assign tx_last = tick && (tx_tck_q == tx_len - 6'h01);

    // current transmit bit from the sequence state
    always_comb begin
        unique case (tx_st_q)
            ulm_pkg::TX_IDLE: tx_bit = 1'b1;
            ulm_pkg::TX_START: tx_bit = 1'b0;
            ulm_pkg::TX_DATA: tx_bit = tsr_q[tx_bit_q];
            ulm_pkg::TX_PAR: tx_bit = par_calc(tsr_q, lfc_q[1:0], lfc_q[`ULM_LFC_EPS],
                                               lfc_q[`ULM_LFC_SP]);
            ulm_pkg::TX_STOP: tx_bit = 1'b1;
            default: tx_bit = 1'b1;
        endcase
    end

    assign tx_line = tx_bit && !lfc_q[`ULM_LFC_BRK];
    assign ir_enc = !tx_line && (tx_tck_q < `ULM_IR_PW);

    // holding register, written by the host, drained by the shifter
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            thr_q <= 8'h00;
            thr_empty_q <= 1'b1;
        end else begin
            // empty on transfer, full on write
            if (wr_thr) begin
                thr_q <= reg_wdata;
                thr_empty_q <= 1'b0;
            end else if (tx_st_q == ulm_pkg::TX_IDLE && !thr_empty_q) begin
                thr_empty_q <= 1'b1;
            end
        end
    end

    // transmit shifter sequence
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_st_q <= ulm_pkg::TX_IDLE;
            tsr_q <= 8'h00;
            tx_tck_q <= 6'h00;
            tx_bit_q <= 3'h0;
        end else if (tx_st_q == ulm_pkg::TX_IDLE) begin
            tx_tck_q <= 6'h00;
            tx_bit_q <= 3'h0;
            if (!thr_empty_q) begin
                tsr_q <= thr_q;
                tx_st_q <= ulm_pkg::TX_START;
            end
        end else if (tick) begin
            tx_tck_q <= tx_last ? 6'h00 : tx_tck_q + 6'h01;
            if (tx_last) begin
                unique case (tx_st_q)
                    ulm_pkg::TX_START: tx_st_q <= ulm_pkg::TX_DATA;
                    ulm_pkg::TX_DATA: begin
                        tx_bit_q <= tx_bit_q + 3'h1;
                        if (tx_bit_q == wl_last) begin
                            tx_st_q <= lfc_q[`ULM_LFC_PEN] ? ulm_pkg::TX_PAR
                                                           : ulm_pkg::TX_STOP;
                        end
                    end
                    ulm_pkg::TX_PAR: tx_st_q <= ulm_pkg::TX_STOP;
                    ulm_pkg::TX_STOP: tx_st_q <= ulm_pkg::TX_IDLE;
                    default: tx_st_q <= ulm_pkg::TX_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // loopback feeds the receiver
    assign rx_line = moc_q[`ULM_MOC_LOOP] ? tx_line :
                     moc_q[`ULM_MOC_IR] ? (ir_cnt_q == 5'h00) : serial_in;

    // infrared decoder stretches each pulse into a zero bit
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ir_cnt_q <= 5'h00;
        end else if (serial_in) begin
            ir_cnt_q <= `ULM_IR_HOLD;
        end else if (tick && ir_cnt_q != 5'h00) begin
            ir_cnt_q <= ir_cnt_q - 5'h01;
        end
    end

    assign rx_done = (rx_st_q == ulm_pkg::RX_STOP) && tick && (rx_tck_q == `ULM_RX_LAST);
    // stop bit check; one driver for the whole carrier
    assign rx_new = '{data: rx_sh_q, par_err: rx_pe_q, frm_err: !rx_line,
                      brk: rx_zero_q && !rx_line};
    assign rx_err = rx_new.frm_err || rx_new.brk || rx_new.par_err;

    // receive sequence, sampling each bit at its middle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_st_q <= ulm_pkg::RX_IDLE;
            rx_tck_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_pe_q <= 1'b0;
            rx_zero_q <= 1'b1;
        end else begin
            if (tick) begin
                rx_tck_q <= rx_tck_q + 4'h1;
            end
            unique case (rx_st_q)
                ulm_pkg::RX_IDLE: begin
                    rx_tck_q <= 4'h0;
                    rx_bit_q <= 3'h0;
                    rx_sh_q <= 8'h00;
                    rx_pe_q <= 1'b0;
                    rx_zero_q <= 1'b1;
                    if (!rx_line) rx_st_q <= ulm_pkg::RX_START;
                end
                ulm_pkg::RX_START: begin
                    // a start bit gone by mid-bit is a glitch
                    if (tick && rx_tck_q == `ULM_RX_MID) begin
                        rx_tck_q <= 4'h0;
                        rx_st_q <= rx_line ? ulm_pkg::RX_IDLE : ulm_pkg::RX_DATA;
                    end
                end
                ulm_pkg::RX_DATA: begin
                    if (tick && rx_tck_q == `ULM_RX_LAST) begin
                        rx_sh_q[rx_bit_q] <= rx_line;
                        rx_zero_q <= rx_zero_q && !rx_line;
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == wl_last) begin
                            rx_st_q <= lfc_q[`ULM_LFC_PEN] ? ulm_pkg::RX_PAR
                                                           : ulm_pkg::RX_STOP;
                        end
                    end
                end
                ulm_pkg::RX_PAR: begin
                    if (tick && rx_tck_q == `ULM_RX_LAST) begin
                        rx_pe_q <= rx_line != par_calc(rx_sh_q, lfc_q[1:0],
                                               lfc_q[`ULM_LFC_EPS], lfc_q[`ULM_LFC_SP]);
                        rx_zero_q <= rx_zero_q && !rx_line;
                        rx_st_q <= ulm_pkg::RX_STOP;
                    end
                end
                ulm_pkg::RX_STOP: begin
                    if (rx_done) begin
                        rx_st_q <= rx_new.brk ? ulm_pkg::RX_BRKW : ulm_pkg::RX_IDLE;
                    end
                end
                ulm_pkg::RX_BRKW: if (rx_line) rx_st_q <= ulm_pkg::RX_IDLE;
                default: rx_st_q <= ulm_pkg::RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // holding register with per-character flags; new data wins a clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hold_q <= '0;
            dr_q <= 1'b0;
        end else if (rx_done && (!dr_q || rd_rhr)) begin
            hold_q <= rx_new;
            dr_q <= 1'b1;
        end else begin
            if (rd_rhr) dr_q <= 1'b0;
            if (rd_lts) begin
                hold_q.par_err <= 1'b0;
                hold_q.frm_err <= 1'b0;
                hold_q.brk <= 1'b0;
            end
        end
    end

    // overrun and line-status interrupt; a set beats the read clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
            ls_pend_q <= 1'b0;
        end else begin
            if (rx_done && dr_q && !rd_rhr) begin
                oe_q <= 1'b1;
            end else if (rd_lts) begin
                oe_q <= 1'b0;
            end
            if (ien_q[`ULM_IEN_LS] && rx_done && ((dr_q && !rd_rhr) ||
                (rx_err && (xfr_bad_q || !dr_q || rd_rhr)))) begin
                ls_pend_q <= 1'b1;
            end else if (rd_lts) begin
                ls_pend_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // empty only when idle
    assign lts = {hold_q.par_err || hold_q.frm_err || hold_q.brk,
                  thr_empty_q && (tx_st_q == ulm_pkg::TX_IDLE), thr_empty_q,
                  hold_q.brk, hold_q.frm_err, hold_q.par_err, oe_q, dr_q};
    assign int_any = ls_pend_q || (ien_q[`ULM_IEN_RDA] && dr_q) ||
                     (ien_q[`ULM_IEN_THRE] && thr_empty_q);

    // read multiplexer; unmapped offsets read zero
    always_comb begin
        rdata_d = 8'h00;
        case (reg_addr)
            `ULM_OFF_DATA: rdata_d = dlab ? div_q[7:0] : hold_q.data;
            `ULM_OFF_IEN: rdata_d = dlab ? div_q[15:8] : {5'h00, ien_q};
            `ULM_OFF_LFC: rdata_d = lfc_q;
            `ULM_OFF_MOC: rdata_d = moc_q;
            `ULM_OFF_LTS: rdata_d = lts;
            default: rdata_d = 8'h00;
        endcase
    end

    // all pins leave from flops so the board sees no decode glitches
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            serial_out <= 1'b1;
            dtr_n <= 1'b1;
            rts_n <= 1'b1;
            gp_output_one_n <= 1'b1;
            gp_output_two_n <= 1'b1;
            pc_interrupt_request <= 1'b0;
            int_out <= 1'b0;
            int_oe_n <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
            serial_out <= moc_q[`ULM_MOC_LOOP] ? !moc_q[`ULM_MOC_IR] :
                          moc_q[`ULM_MOC_IR] ? ir_enc : tx_line;
            dtr_n <= !moc_q[`ULM_MOC_DTR];
            gp_output_one_n <= !moc_q[`ULM_MOC_OP1];
            rts_n <= efr_arts_q ? dr_q : !moc_q[`ULM_MOC_RTS];
            gp_output_two_n <= pc_bus_mode || !moc_q[`ULM_MOC_OP2];
            pc_interrupt_request <= pc_bus_mode && moc_q[`ULM_MOC_OP2] && int_any;
            int_out <= int_any;
            int_oe_n <= moc_q[`ULM_MOC_OSRC] && !int_any;
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_break_line_low:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        lfc_q[`ULM_LFC_BRK] && !moc_q[`ULM_MOC_LOOP] && !moc_q[`ULM_MOC_IR]
        |=> !serial_out) else $error("break did not hold line low");
    a_loop_line_idle:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        moc_q[`ULM_MOC_LOOP] && !moc_q[`ULM_MOC_IR] |=> serial_out)
        else $error("line not idle in loopback");
    a_ir_idle_low:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        moc_q[`ULM_MOC_IR] && !moc_q[`ULM_MOC_LOOP] && tx_st_q == ulm_pkg::TX_IDLE
        && !lfc_q[`ULM_LFC_BRK] |=> !serial_out) else $error("infrared idle not low");
    a_dlab_write_div:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == `ULM_OFF_DATA && dlab
        |=> div_q[7:0] == $past(reg_wdata) && thr_q == $past(thr_q))
        else $error("divisor write misrouted");
    a_thre_on_write:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_thr && thr_empty_q && tx_st_q == ulm_pkg::TX_IDLE
        |=> !thr_empty_q ##1 (tx_st_q != ulm_pkg::TX_IDLE))
        else $error("holding write not taken");
    a_ready_on_char:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        rx_done && !dr_q |=> dr_q && hold_q.data == $past(rx_sh_q))
        else $error("received char not held");
    a_overrun_keeps:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        rx_done && dr_q && !rd_rhr |=> oe_q && hold_q.data == $past(hold_q.data))
        else $error("overrun handling wrong");
    a_break_read_clr:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_lts && !rx_done |=> !hold_q.brk && !oe_q)
        else $error("status read did not clear flags");
    a_prescale_gap:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        moc_q[`ULM_MOC_PRE] && $past(moc_q[`ULM_MOC_PRE]) && pre_tick
        |=> (!pre_tick || !moc_q[`ULM_MOC_PRE]) [*3])
        else $error("prescaler not dividing by four");
    a_dtr_low_active:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(moc_q[`ULM_MOC_DTR]) |=> !dtr_n) else $error("terminal ready not low");
    a_temt_idle:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_thr |=> (!lts[6]) [*2]) else $error("transmitter empty while loaded");

endmodule : ulm_line_ctrl

/* tb/ulm_line_partner.sv */
/*
 * remote serial sender: one frame of start, 8 data, parity and stop per go pulse.
 * assumes divisor 1 and no prescaler in the block, so 16 clocks a bit.
 */
`timescale 1ns/10ps
module ulm_line_partner (
    input wire logic clk_sys, // system clock
    input wire logic go, // start one frame
    input wire logic [8:0] frame, // parity bit above data
    output logic line // serial line into the block
);
    int i;
    // line idles at mark, as a real sender leaves it
    initial line = 1'b1;
    always @(posedge clk_sys) begin
        if (go) begin
            line <= 1'b0;
            repeat (16) @(posedge clk_sys);
            for (i = 0; i < 9; i++) begin
                line <= frame[i];
                repeat (16) @(posedge clk_sys);
            end
            line <= 1'b1;
        end
    end
endmodule : ulm_line_partner

/* tb/tb_ulm_line_ctrl.sv */
/*
 * bench for the line control block: modem outputs, loopback, break, parity.
 * assumes the partner model on serial_in and the register port of the block.
 */
`timescale 1ns/10ps
module tb_ulm_line_ctrl;
    logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, go = 0, so;
    logic [2:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, v;
    logic [8:0] frame = 0;
    logic sin, dtr_n, rts_n, op1_n, op2_n, irq, iout, ioe_n, pc = 0, irs = 0;
    logic [7:0] row_in [6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h80};
    logic [3:0] row_out [6] = '{4'hF, 4'h7, 4'hB, 4'hD, 4'hE, 4'hF};
    int err_total = 0, checks_done = 0, k;
    ulm_line_partner far (.clk_sys(clk_sys), .go(go), .frame(frame), .line(sin));
    ulm_line_ctrl uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_in(sin), .serial_out(so), .infrared_select_pin(irs), .pc_bus_mode(pc),
        .dtr_n(dtr_n), .rts_n(rts_n), .gp_output_one_n(op1_n), .gp_output_two_n(op2_n),
        .pc_interrupt_request(irq), .int_out(iout), .int_oe_n(ioe_n));
    initial forever #10 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    // one compare; a mismatch prints at once
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk_sys) reg_wr <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe edge
    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys) reg_rd <= 1'b0;
        @(negedge clk_sys) d = reg_rdata;
    endtask : rd
    // bounded poll for data ready; also watches the line stays idle
    task wait_dr(input logic idle);
        for (k = 0; k < 400; k++) begin
            rd(3'h5, v);
            if (idle) chk("line idle", 8'h01, {7'h0, so});
            if (v[0] === 1'b1) return;
        end
        chk("ready timeout", 8'h01, 8'h00);
        stop_test();
    endtask : wait_dr
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(3'h5, v);
        chk("status reset", 8'h60, v);
        chk("modem reset", 8'h0F, {4'h0, dtr_n, rts_n, op1_n, op2_n});
        $display("test reset done");
        for (int r = 0; r < 6; r++) begin
            wr(3'h4, row_in[r]);
            // pins leave from flops one edge after the register updates
            repeat (2) @(negedge clk_sys);
            chk("modem pins", {4'h0, row_out[r]}, {4'h0, dtr_n, rts_n, op1_n, op2_n});
            rd(3'h4, v);
            chk("modem readback", row_in[r], v);
        end
        $display("test modem rows done");
        wr(3'h3, 8'h03);
        wr(3'h4, 8'h10);
        wr(3'h0, 8'hA5);
        wait_dr(1'b1);
        rd(3'h0, v);
        chk("loop data", 8'hA5, v);
        wr(3'h4, 8'h00);
        $display("test loopback done");
        wr(3'h3, 8'h83);
        wr(3'h0, 8'h5A);
        rd(3'h0, v);
        chk("divisor low", 8'h5A, v);
        wr(3'h0, 8'h01);
        wr(3'h3, 8'hBF);
        rd(3'h0, v);
        chk("data at key", 8'hA5, v);
        $display("test divisor done");
        wr(3'h3, 8'h0B);
        @(posedge clk_sys) {go, frame} <= {1'b1, 9'h101};
        @(posedge clk_sys) go <= 1'b0;
        wait_dr(1'b0);
        chk("parity flag", 8'h05, v & 8'h05);
        rd(3'h5, v);
        chk("parity clear", 8'h00, v & 8'h04);
        rd(3'h0, v);
        chk("rx data", 8'h01, v);
        $display("test parity done");
        wr(3'h3, 8'h40);
        repeat (3) @(negedge clk_sys);
        chk("break low", 8'h00, {7'h0, so});
        wr(3'h3, 8'h00);
        repeat (3) @(negedge clk_sys);
        chk("break off", 8'h01, {7'h0, so});
        $display("test break done");
        @(posedge clk_sys) pc <= 1'b1;
        wr(3'h4, 8'h28);
        wr(3'h1, 8'h02);
        repeat (2) @(negedge clk_sys);
        chk("irq pins on", 8'h0D, {4'h0, irq, iout, ioe_n, op2_n});
        wr(3'h1, 8'h00);
        repeat (2) @(negedge clk_sys);
        chk("irq pins off", 8'h03, {4'h0, irq, iout, ioe_n, op2_n});
        @(posedge clk_sys) pc <= 1'b0;
        $display("test interrupt pins done");
        wr(3'h3, 8'h03);
        wr(3'h4, 8'h10);
        wr(3'h0, 8'h11);
        wait_dr(1'b1);
        wr(3'h0, 8'h22);
        rd(3'h5, v);
        chk("temt busy", 8'h00, v & 8'h40);
        repeat (200) @(posedge clk_sys);
        rd(3'h5, v);
        chk("overrun flag", 8'h03, v & 8'h03);
        rd(3'h0, v);
        chk("overrun data", 8'h11, v);
        $display("test overrun done");
        // second reset in mid-run, with the infrared strap high
        wr(3'h4, 8'h01);
        @(posedge clk_sys) {rst_n, irs} <= 2'b01;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(3'h5, v);
        chk("status rerun", 8'h60, v);
        rd(3'h4, v);
        chk("strap ir", 8'h40, v);
        chk("ir idle", 8'h00, {7'h0, so});
        chk("modem rerun", 8'h0F, {4'h0, dtr_n, rts_n, op1_n, op2_n});
        wr(3'h4, 8'h00);
        rd(3'h4, v);
        chk("strap override", 8'h00, v);
        $display("test rerun done");
        stop_test();
    end
endmodule : tb_ulm_line_ctrl
